// ---- crc7_calc.sv ----
`timescale 1ns/10ps
module crc7_calc (
   input wire logic [fault_mon_pkg::CRC_MAX_BITS-1:0] bits_i,
   input wire logic [4:0] nbits_i,
   output logic [fault_mon_pkg::CRC_W-1:0] crc_o
);
   import fault_mon_pkg::*;

   // Bits are taken from the top down, in the order they cross the link.
   always_comb begin
      logic [CRC_W-1:0] c;
      logic fb;
      c = CRC_INIT;
      fb = 1'b0;
      for (int i = 0; i < CRC_MAX_BITS; i++) begin
         if (5'(i) < nbits_i) begin
            fb = bits_i[CRC_MAX_BITS-1-i] ^ c[CRC_W-1];
            c = {c[CRC_W-2:0], 1'b0} ^ (fb ? CRC_POLY : 7'h00);
         end
      end
      crc_o = c;
   end

endmodule : crc7_calc

// ---- fault_and_serial_error_monitor.sv ----
`timescale 1ns/10ps
// Contract
// - Channel overtemp turns channel off, flags it.
// - Die overtemp turns all off, bit 3.
// - Open load only when enabled, high-side.
// - Undervoltage turns channels, LEDs off; bits 0-2.
// - Watchdog timeout sets bit 7, pin high.
// - Clock count not multiple of eight: error.
// - Check failure discards data, sets bit 6.
// - Overcurrent: slow flag, short alert pulse.
// - Outside command mode alert is fault OR.
// - Command mode alert latches until clear.
// - Switches use raw thermal; logic stretches it.
// - Checking only in serial mode, pin enabled.
// - Seven-bit check, given polynomial, start all ones.
// - Input check covers data plus leading one.
// - Only verified data updates outputs or configuration.
// - Feedback bit reports previous reception's check error.
// - Output check covers diagnostics plus feedback bit.
// - Latched faults clear on clean clear transaction in command mode.
// - Thermal, open-load, clock-count indications last 200ms.
module fault_and_serial_error_monitor #(
   parameter logic [fault_mon_pkg::CNT_W-1:0] STRETCH_CYCLES = fault_mon_pkg::STRETCH_CYCLES,
   parameter logic [fault_mon_pkg::CNT_W-1:0] WD_LONG_CYCLES = fault_mon_pkg::WD_LONG_CYCLES,
   parameter logic [fault_mon_pkg::CNT_W-1:0] WD_MID_CYCLES = fault_mon_pkg::WD_MID_CYCLES,
   parameter logic [fault_mon_pkg::CNT_W-1:0] WD_SHORT_CYCLES = fault_mon_pkg::WD_SHORT_CYCLES
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic cs_n_i,
   input wire logic sck_i,
   input wire logic sdi_i,
   output logic sdo_o,
   input wire fault_mon_pkg::analog_in_t analog_i,
   input wire logic [fault_mon_pkg::NUM_CH-1:0] channel_on_i,
   input wire logic [fault_mon_pkg::NUM_CH-1:0] push_pull_i,
   input wire logic [fault_mon_pkg::NUM_CH-1:0] open_load_enable_i,
   input wire logic watchdog_enable_i,
   input wire logic [1:0] watchdog_select_i,
   input wire logic check_enable_pin_i,
   input wire logic serial_setting_select_i,
   input wire logic command_protocol_select_i,
   input wire logic frame_wide_i,
   input wire logic [15:0] diag_data_i,
   output logic [fault_mon_pkg::NUM_CH-1:0] upper_switch_o,
   output logic [fault_mon_pkg::NUM_CH-1:0] lower_switch_o,
   output logic [fault_mon_pkg::NUM_CH-1:0] led_o,
   output logic fault_n_o,
   output logic watchdog_alert_out_o,
   output logic check_error_feedback_o,
   output logic [fault_mon_pkg::NUM_CH-1:0] overvoltage_slow_flag_o,
   output logic rx_valid_o,
   output logic [15:0] rx_data_o,
   output fault_mon_pkg::fault_regs_t latched_o,
   output fault_mon_pkg::fault_regs_t realtime_o
);
   import fault_mon_pkg::*;

   localparam int SW = $bits(analog_in_t) + 7;
   localparam int NST = 2 * NUM_CH + 2;
   localparam logic [SW-1:0] SYNC_INIT = {{(SW-3){1'b0}}, 3'h4};

   logic [SW-1:0] sync_a;
   logic [SW-1:0] sync_b;
   analog_in_t an;
   logic crc_pin;
   logic serial_sel;
   logic cmd_sel;
   logic wide_sel;
   logic cs_n;
   logic sck;
   logic sdi;
   logic cs_prev;
   logic sck_prev;
   logic cs_fall;
   logic cs_rise;
   logic sck_rise;
   logic sck_fall;

   // Analog, mode-select and serial pin inputs pass two flip-flops before use.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sync_a <= SYNC_INIT;
         sync_b <= SYNC_INIT;
         cs_prev <= 1'b1;
         sck_prev <= 1'b0;
      end else begin
         sync_a <= {analog_i, check_enable_pin_i, serial_setting_select_i,
                    command_protocol_select_i, frame_wide_i, cs_n_i, sck_i, sdi_i};
         sync_b <= sync_a;
         cs_prev <= cs_n;
         sck_prev <= sck;
      end
   end

   assign {an, crc_pin, serial_sel, cmd_sel, wide_sel, cs_n, sck, sdi} = sync_b;
   assign cs_fall = cs_prev & ~cs_n;
   assign cs_rise = ~cs_prev & cs_n;
   assign sck_rise = ~cs_n & sck & ~sck_prev;
   assign sck_fall = ~cs_n & ~sck & sck_prev;

   logic crc_on;
   assign crc_on = crc_pin & serial_sel;

   // Serial shifting.
   logic [FRAME_W-1:0] rx_shift;
   logic [FRAME_W-1:0] tx_shift;
   logic [FRAME_W-1:0] tx_frame;
   logic [2:0] bit_cnt;
   logic any_clock;
   logic sdi_last;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rx_shift <= '0;
         tx_shift <= '0;
         bit_cnt <= 3'h0;
         any_clock <= 1'b0;
         sdi_last <= 1'b0;
      end else if (cs_fall) begin
         tx_shift <= tx_frame;
         bit_cnt <= 3'h0;
         any_clock <= 1'b0;
      end else begin
         if (sck_rise) begin
            rx_shift <= {rx_shift[FRAME_W-2:0], sdi};
            bit_cnt <= bit_cnt + 3'h1;
            any_clock <= 1'b1;
            sdi_last <= sdi;
         end
         // Bits received are passed on behind our own for daisy chaining.
         if (sck_fall) begin
            tx_shift <= {tx_shift[FRAME_W-2:0], sdi_last};
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sdo_o <= 1'b0;
      end else begin
         sdo_o <= tx_shift[FRAME_W-1];
      end
   end

   // Output check byte: feedback bit, then check bits six down to zero.
   logic [CRC_MAX_BITS-1:0] tx_bits;
   logic [CRC_W-1:0] tx_crc;
   assign tx_bits = frame_wide_sel_bits(wide_sel, diag_data_i, check_error_feedback_o);

   function automatic logic [CRC_MAX_BITS-1:0] frame_wide_sel_bits(
      input logic wide, input logic [15:0] d, input logic fb);
      frame_wide_sel_bits = wide ? {d, fb} : {d[7:0], fb, 8'h00};
   endfunction : frame_wide_sel_bits

   crc7_calc u_tx_crc (
      .bits_i(tx_bits),
      .nbits_i(wide_sel ? CRC_BITS_WIDE : CRC_BITS_NARROW),
      .crc_o(tx_crc)
   );

   always_comb begin
      if (!crc_on) begin
         tx_frame = wide_sel ? {diag_data_i, 8'h00} : {diag_data_i[7:0], 16'h0000};
      end else if (wide_sel) begin
         tx_frame = {diag_data_i, check_error_feedback_o, tx_crc};
      end else begin
         tx_frame = {diag_data_i[7:0], check_error_feedback_o, tx_crc, 8'h00};
      end
   end

   // The last bits received belong to this device, so daisy chains work.
   logic [15:0] rx_data;
   logic [CRC_MAX_BITS-1:0] rx_bits;
   logic [CRC_W-1:0] rx_crc;
   logic check_err;
   logic count_err;
   logic serial_err;
   logic clear_ok;
   logic z_bit;

   always_comb begin
      if (crc_on) begin
         rx_data = wide_sel ? rx_shift[23:8] : {8'h00, rx_shift[15:8]};
      end else begin
         rx_data = wide_sel ? rx_shift[15:0] : {8'h00, rx_shift[7:0]};
      end
   end

   assign rx_bits = wide_sel ? rx_shift[23:7] : {rx_shift[15:7], 8'h00};

   crc7_calc u_rx_crc (
      .bits_i(rx_bits),
      .nbits_i(wide_sel ? CRC_BITS_WIDE : CRC_BITS_NARROW),
      .crc_o(rx_crc)
   );

   assign check_err = crc_on & (~rx_shift[7] | (rx_crc != rx_shift[6:0]));
   assign count_err = bit_cnt != 3'h0;
   assign serial_err = check_err | count_err;
   assign z_bit = wide_sel ? rx_data[15] : rx_data[7];
   assign clear_ok = cs_rise & any_clock & cmd_sel & z_bit & ~serial_err;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rx_valid_o <= 1'b0;
         rx_data_o <= 16'h0000;
         check_error_feedback_o <= 1'b0;
      end else begin
         rx_valid_o <= cs_rise & any_clock & ~serial_err;
         if (cs_rise && any_clock && !serial_err) begin
            rx_data_o <= rx_data;
         end
         if (cs_rise) begin
            check_error_feedback_o <= check_err;
         end
      end
   end

   // Fault sources.
   logic [NUM_CH-1:0] ch_hot;
   logic [NUM_CH-1:0] ol_raw;
   logic [NST-1:0] st_src;
   logic [NST-1:0] stretched;
   logic [CNT_W-1:0] st_cnt [NST];

   assign ch_hot = an.hot_upper | an.hot_lower;
   assign ol_raw = open_load_enable_i & ~push_pull_i &
                   ((channel_on_i & an.on_current_low) | (~channel_on_i & an.off_current_low));
   assign st_src = {ch_hot, ol_raw, an.die_hot, cs_rise & count_err};

   for (genvar i = 0; i < NST; i++) begin : g_stretch
      always_ff @(posedge clk_i) begin
         if (rst_i) begin
            st_cnt[i] <= '0;
            stretched[i] <= 1'b0;
         end else if (st_src[i]) begin
            st_cnt[i] <= STRETCH_CYCLES - 1'b1;
            stretched[i] <= 1'b1;
         end else if (st_cnt[i] != '0) begin
            st_cnt[i] <= st_cnt[i] - 1'b1;
            stretched[i] <= 1'b1;
         end else begin
            stretched[i] <= 1'b0;
         end
      end
   end

   // Watchdog on chip-select falling edges.
   logic [CNT_W-1:0] wd_cnt;
   logic [CNT_W-1:0] wd_limit;

   always_comb begin
      case (watchdog_select_i)
         WD_SEL_LONG: wd_limit = WD_LONG_CYCLES;
         WD_SEL_MID: wd_limit = WD_MID_CYCLES;
         WD_SEL_SHORT: wd_limit = WD_SHORT_CYCLES;
         default: wd_limit = WD_SHORT_CYCLES;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i || cs_fall || !watchdog_enable_i) begin
         wd_cnt <= '0;
         watchdog_alert_out_o <= 1'b0;
      end else if (wd_cnt >= wd_limit) begin
         watchdog_alert_out_o <= 1'b1;
      end else begin
         wd_cnt <= wd_cnt + 1'b1;
      end
   end

   // Short circuit detection.
   logic [NUM_CH-1:0] oc_prev;
   logic [11:0] pulse_cnt;
   logic short_alert;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         oc_prev <= '0;
         pulse_cnt <= 12'h000;
         overvoltage_slow_flag_o <= '0;
      end else begin
         oc_prev <= an.over_current;
         overvoltage_slow_flag_o <= an.over_current;
         if (|(an.over_current & ~oc_prev)) begin
            pulse_cnt <= ALERT_PULSE_CYCLES;
         end else if (pulse_cnt != 12'h000) begin
            pulse_cnt <= pulse_cnt - 12'h001;
         end
      end
   end
   assign short_alert = pulse_cnt != 12'h000;

   // Real-time fault view.
   fault_regs_t rt;
   logic any_rt;

   always_comb begin
      rt.thermal = stretched[NST-1 -: NUM_CH];
      rt.open_load = stretched[NUM_CH+1:2];
      rt.global_faults = FAULT_RESET;
      rt.global_faults[G_VDD_WARN] = an.vdd_warn;
      rt.global_faults[G_VDD_UVLO] = an.vdd_uvlo;
      rt.global_faults[G_V5_UVLO] = an.v5_uvlo;
      rt.global_faults[G_DIE_HOT] = stretched[1];
      rt.global_faults[G_CLK_COUNT] = stretched[0];
      rt.global_faults[G_DCDC_LIMIT] = an.dcdc_limit;
      rt.global_faults[G_CHECK] = check_error_feedback_o;
      rt.global_faults[G_WATCHDOG] = watchdog_alert_out_o;
   end
   assign any_rt = (|rt) | short_alert;

   // Latched faults and the command-mode alert; a set wins over a clear.
   logic irq;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         latched_o <= '0;
         realtime_o <= '0;
         irq <= 1'b0;
         fault_n_o <= 1'b1;
      end else begin
         realtime_o <= rt;
         latched_o <= clear_ok ? rt : (latched_o | rt);
         irq <= any_rt | (irq & ~clear_ok);
         fault_n_o <= cmd_sel ? ~(any_rt | (irq & ~clear_ok)) : ~any_rt;
      end
   end

   // Drivers react to raw thermal levels, not stretched ones.
   logic [NUM_CH-1:0] off_vec;
   logic uvlo;
   assign uvlo = an.vdd_uvlo | an.v5_uvlo;
   assign off_vec = ch_hot | {NUM_CH{an.die_hot | uvlo}};

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         upper_switch_o <= '0;
         lower_switch_o <= '0;
         led_o <= '0;
      end else begin
         upper_switch_o <= channel_on_i & ~off_vec;
         lower_switch_o <= ~channel_on_i & push_pull_i & ~off_vec;
         led_o <= uvlo ? '0 : channel_on_i;
      end
   end

endmodule : fault_and_serial_error_monitor

// ---- fault_mon_asserts.sv ----
`timescale 1ns/10ps
module fault_mon_asserts (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic cs_n_i,
   input wire fault_mon_pkg::analog_in_t analog_i,
   input wire logic command_protocol_select_i,
   input wire logic [fault_mon_pkg::NUM_CH-1:0] upper_switch_o,
   input wire logic [fault_mon_pkg::NUM_CH-1:0] lower_switch_o,
   input wire logic [fault_mon_pkg::NUM_CH-1:0] led_o,
   input wire logic fault_n_o,
   input wire logic watchdog_alert_out_o,
   input wire logic check_error_feedback_o,
   input wire logic [fault_mon_pkg::NUM_CH-1:0] overvoltage_slow_flag_o,
   input wire logic rx_valid_o,
   input wire logic [15:0] rx_data_o,
   input wire fault_mon_pkg::fault_regs_t realtime_o
);
   import fault_mon_pkg::*;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   a_valid_pulse: assert property (
      rx_valid_o |=> !rx_valid_o) else $error("rx_valid_o longer than one cycle");
   a_valid_clean: assert property (
      rx_valid_o |-> !check_error_feedback_o && cs_n_i) else $error("accepted frame flagged");
   a_data_hold: assert property (
      !rx_valid_o |-> $stable(rx_data_o)) else $error("rx_data_o changed without accept");
   a_chan_hot: assert property (
      ($stable(analog_i.hot_upper | analog_i.hot_lower) &&
       (analog_i.hot_upper | analog_i.hot_lower) != '0) [*4] |->
      ((upper_switch_o | lower_switch_o) & (analog_i.hot_upper | analog_i.hot_lower)) == '0)
      else $error("hot channel still switched");
   a_die_off: assert property (
      analog_i.die_hot [*4] |-> upper_switch_o == '0 && lower_switch_o == '0)
      else $error("die overtemp left a switch on");
   a_uvlo_off: assert property (
      (analog_i.vdd_uvlo || analog_i.v5_uvlo) [*4] |-> led_o == '0 && upper_switch_o == '0)
      else $error("undervoltage left an output on");
   a_fault_or: assert property (
      (!command_protocol_select_i && realtime_o != '0) [*4] |-> !fault_n_o)
      else $error("alert high with fault present");
   a_wd_release: assert property (
      $fell(cs_n_i) && watchdog_alert_out_o |-> ##[1:5] !watchdog_alert_out_o)
      else $error("watchdog pin not released");
   a_slow_flag: assert property (
      $stable(analog_i.over_current) [*4] |-> overvoltage_slow_flag_o == analog_i.over_current)
      else $error("slow flag differs from overcurrent");
   c_accept: cover property (rx_valid_o);
   c_wd_fire: cover property ($rose(watchdog_alert_out_o));
   c_alert: cover property ($fell(fault_n_o));
   c_feedback: cover property (check_error_feedback_o);
endmodule : fault_mon_asserts

bind fault_and_serial_error_monitor fault_mon_asserts i_fault_mon_asserts (.clk_i, .rst_i,
   .cs_n_i, .analog_i, .command_protocol_select_i, .upper_switch_o, .lower_switch_o, .led_o,
   .fault_n_o, .watchdog_alert_out_o, .check_error_feedback_o, .overvoltage_slow_flag_o,
   .rx_valid_o, .rx_data_o, .realtime_o);

// ---- fault_mon_pkg.sv ----
package fault_mon_pkg;

   localparam int NUM_CH = 8;
   localparam int CNT_W = 25;

   // Clock and timing.
   localparam int CLK_PERIOD_NS = 50;
   localparam longint STRETCH_MS = 200;
   localparam longint WD_LONG_MS = 1200;
   localparam longint WD_MID_MS = 600;
   localparam longint WD_SHORT_MS = 200;
   localparam int ALERT_PULSE_US = 100;
   localparam logic [CNT_W-1:0] STRETCH_CYCLES =
      CNT_W'(STRETCH_MS * 64'd1000000 / CLK_PERIOD_NS);
   localparam logic [CNT_W-1:0] WD_LONG_CYCLES =
      CNT_W'(WD_LONG_MS * 64'd1000000 / CLK_PERIOD_NS);
   localparam logic [CNT_W-1:0] WD_MID_CYCLES =
      CNT_W'(WD_MID_MS * 64'd1000000 / CLK_PERIOD_NS);
   localparam logic [CNT_W-1:0] WD_SHORT_CYCLES =
      CNT_W'(WD_SHORT_MS * 64'd1000000 / CLK_PERIOD_NS);
   localparam logic [11:0] ALERT_PULSE_CYCLES = 12'(ALERT_PULSE_US * 1000 / CLK_PERIOD_NS);

   // Watchdog period selects.
   localparam logic [1:0] WD_SEL_LONG = 2'h0;
   localparam logic [1:0] WD_SEL_MID = 2'h1;
   localparam logic [1:0] WD_SEL_SHORT = 2'h2;

   // Frame check sequence.
   localparam int CRC_W = 7;
   localparam logic [CRC_W-1:0] CRC_POLY = 7'h37;
   localparam logic [CRC_W-1:0] CRC_INIT = 7'h7f;
   localparam int CRC_MAX_BITS = 17;
   localparam logic [4:0] CRC_BITS_WIDE = 5'h11;
   localparam logic [4:0] CRC_BITS_NARROW = 5'h09;
   localparam int FRAME_W = 24;

   // Global fault register bit positions.
   localparam int G_VDD_WARN = 0;
   localparam int G_VDD_UVLO = 1;
   localparam int G_V5_UVLO = 2;
   localparam int G_DIE_HOT = 3;
   localparam int G_CLK_COUNT = 4;
   localparam int G_DCDC_LIMIT = 5;
   localparam int G_CHECK = 6;
   localparam int G_WATCHDOG = 7;

   // Reset values of fault registers.
   localparam logic [7:0] FAULT_RESET = 8'h00;

   typedef struct packed {
      logic [NUM_CH-1:0] hot_upper;
      logic [NUM_CH-1:0] hot_lower;
      logic [NUM_CH-1:0] on_current_low;
      logic [NUM_CH-1:0] off_current_low;
      logic [NUM_CH-1:0] over_current;
      logic die_hot;
      logic vdd_uvlo;
      logic v5_uvlo;
      logic vdd_warn;
      logic dcdc_limit;
   } analog_in_t;

   typedef struct packed {
      logic [NUM_CH-1:0] open_load;
      logic [NUM_CH-1:0] thermal;
      logic [7:0] global_faults;
   } fault_regs_t;

endpackage : fault_mon_pkg

// ---- spi_host_model.sv ----
`timescale 1ns/10ps
module spi_host_model (
   output logic cs_n_o,
   output logic sck_o,
   output logic sdi_o,
   input wire logic sdo_i
);
   logic [23:0] got;
   initial begin
      cs_n_o = 1'b1;
      sck_o = 1'b0;
      sdi_o = 1'b0;
      got = '0;
   end
   // The long low phase gives the synchronised output time to settle before sampling.
   task automatic xfer(input logic [23:0] v, input logic [4:0] n);
      cs_n_o = 1'b0;
      #400;
      for (int i = int'(n) - 1; i >= 0; i--) begin
         sdi_o = v[i];
         #300 sck_o = 1'b1;
         got = {got[22:0], sdo_i};
         #100 sck_o = 1'b0;
      end
      #200 cs_n_o = 1'b1;
      sdi_o = ~sdi_o;
      #400;
   endtask : xfer
endmodule : spi_host_model

// ---- tb.sv ----
`timescale 1ns/10ps
module tb;
   import fault_mon_pkg::*;
   localparam logic [CNT_W-1:0] STR = 50;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cs_n_i, sck_i, sdi_i, sdo_o;
   analog_in_t analog_i;
   logic [NUM_CH-1:0] channel_on_i, push_pull_i, open_load_enable_i;
   logic watchdog_enable_i, check_enable_pin_i, serial_setting_select_i;
   logic command_protocol_select_i, frame_wide_i;
   logic [1:0] watchdog_select_i;
   logic [15:0] diag_data_i, rx_data_o;
   logic [NUM_CH-1:0] upper_switch_o, lower_switch_o, led_o, overvoltage_slow_flag_o;
   logic fault_n_o, watchdog_alert_out_o, check_error_feedback_o, rx_valid_o;
   fault_regs_t latched_o, realtime_o;
   int err_total = 0;
   int num_checks = 0;
   int k;
   logic [15:0] exp_q[$];

   always #25 clk_i = ~clk_i;

   spi_host_model i_spi_host_model (.cs_n_o(cs_n_i), .sck_o(sck_i), .sdi_o(sdi_i),
      .sdo_i(sdo_o));
   fault_and_serial_error_monitor #(.STRETCH_CYCLES(STR), .WD_LONG_CYCLES(25'd900),
      .WD_MID_CYCLES(25'd600), .WD_SHORT_CYCLES(25'd300)) i_fault_and_serial_error_monitor (
      .clk_i, .rst_i, .cs_n_i, .sck_i, .sdi_i, .sdo_o, .analog_i, .channel_on_i, .push_pull_i,
      .open_load_enable_i, .watchdog_enable_i, .watchdog_select_i, .check_enable_pin_i,
      .serial_setting_select_i, .command_protocol_select_i, .frame_wide_i, .diag_data_i,
      .upper_switch_o, .lower_switch_o, .led_o, .fault_n_o, .watchdog_alert_out_o,
      .check_error_feedback_o, .overvoltage_slow_flag_o, .rx_valid_o, .rx_data_o,
      .latched_o, .realtime_o);

   function automatic logic [6:0] crc7(input logic [16:0] b, input int n);
      logic [6:0] c;
      c = CRC_INIT;
      for (int i = n - 1; i >= 0; i--) begin
         c = {c[5:0], 1'b0} ^ ((c[6] ^ b[i]) ? CRC_POLY : 7'h00);
      end
      return c;
   endfunction : crc7

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (e !== g) begin
         err_total++;
         $display("unexpected %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   task automatic cyc(input int n);
      repeat (n) @(posedge clk_i);
      #2;
   endtask : cyc

   // A nonzero trim drops the leading clocks, so the frame must be refused.
   task automatic frame(input logic [15:0] d, input logic w, input logic crc, input logic bad,
         input logic [4:0] trim);
      logic [23:0] v;
      logic [4:0] n;
      n = w ? 5'd16 : 5'd8;
      v = w ? {8'h00, d} : {16'h0000, d[7:0]};
      if (crc) begin
         v = {v[15:0], 1'b1, crc7(w ? {d, 1'b1} : {8'h00, d[7:0], 1'b1}, n + 1) ^ {6'h0, bad}};
         n = n + 5'd8;
      end
      if (!bad && trim == 0) exp_q.push_back(w ? d : {8'h00, d[7:0]});
      i_spi_host_model.xfer(v, n - trim);
      cyc(8);
   endtask : frame

   task automatic conclude;
      if (err_total == 0 && num_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : conclude

   always @(posedge clk_i) begin
      if (rx_valid_o === 1'b1) begin
         if (exp_q.size() == 0) chk("rx_valid_o", 0, 1);
         else chk("rx_data_o", exp_q.pop_front(), rx_data_o);
      end
   end

   initial begin
      #3000000;
      err_total++;
      conclude();
   end

   initial begin
      void'($urandom(5699));
      analog_i = '0;
      channel_on_i = 8'h0f;
      push_pull_i = 8'hff;
      open_load_enable_i = '0;
      watchdog_enable_i = 1'b0;
      watchdog_select_i = WD_SEL_SHORT;
      check_enable_pin_i = 1'b1;
      serial_setting_select_i = 1'b1;
      command_protocol_select_i = 1'b0;
      frame_wide_i = 1'b0;
      diag_data_i = '0;
      cyc(4);
      rst_i = 1'b0;
      cyc(4);
      chk("fault_n_o", 1, fault_n_o);
      chk("latched_o", 0, latched_o);
      repeat (4) begin
         frame(16'($urandom), 0, 1, 0, 0);
         chk("check_error_feedback_o", 0, check_error_feedback_o);
      end
      frame(16'($urandom), 0, 1, 1, 0);
      chk("latched check bit", 1, latched_o.global_faults[G_CHECK]);
      chk("check_error_feedback_o", 1, check_error_feedback_o);
      diag_data_i = 16'($urandom);
      frame(16'($urandom), 0, 1, 0, 0);
      chk("sdo frame", {diag_data_i[7:0], 1'b1, crc7({8'h00, diag_data_i[7:0], 1'b1}, 9)},
         i_spi_host_model.got[15:0]);
      chk("check_error_feedback_o", 0, check_error_feedback_o);
      frame(16'($urandom), 0, 1, 0, 1);
      chk("latched count bit", 1, latched_o.global_faults[G_CLK_COUNT]);
      chk("fault_n_o", 0, fault_n_o);
      cyc(STR + 10);
      chk("realtime count bit", 0, realtime_o.global_faults[G_CLK_COUNT]);
      serial_setting_select_i = 1'b0;
      frame_wide_i = 1'b1;
      cyc(4);
      frame(16'($urandom), 1, 0, 0, 0);
      serial_setting_select_i = 1'b1;
      check_enable_pin_i = 1'b0;
      cyc(4);
      frame(16'($urandom), 1, 0, 0, 0);
      check_enable_pin_i = 1'b1;
      cyc(4);
      frame(16'($urandom), 1, 1, 0, 0);
      chk("sdo wide", {diag_data_i, 1'b0, crc7({diag_data_i, 1'b0}, 17)},
         i_spi_host_model.got);
      frame_wide_i = 1'b0;
      k = $urandom_range(7, 0);
      analog_i.hot_lower = 8'h01 << k;
      cyc(5);
      chk("upper_switch_o", 8'h0f & ~(8'h01 << k), upper_switch_o);
      chk("lower_switch_o", 8'hf0 & ~(8'h01 << k), lower_switch_o);
      analog_i.hot_lower = '0;
      cyc(5);
      chk("upper_switch_o", 8'h0f, upper_switch_o);
      chk("realtime thermal", 8'h01 << k, realtime_o.thermal);
      cyc(STR);
      chk("realtime thermal", 0, realtime_o.thermal);
      chk("latched thermal", 8'h01 << k, latched_o.thermal);
      analog_i.die_hot = 1'b1;
      cyc(5);
      chk("switches", 0, {upper_switch_o, lower_switch_o});
      chk("realtime die bit", 1, realtime_o.global_faults[G_DIE_HOT]);
      analog_i.die_hot = 1'b0;
      analog_i.vdd_uvlo = 1'b1;
      cyc(5);
      chk("led_o", 0, led_o);
      chk("realtime vdd bit", 1, realtime_o.global_faults[G_VDD_UVLO]);
      analog_i.vdd_uvlo = 1'b0;
      analog_i.v5_uvlo = 1'b1;
      cyc(5);
      chk("realtime v5 bit", 1, realtime_o.global_faults[G_V5_UVLO]);
      analog_i.v5_uvlo = 1'b0;
      push_pull_i = 8'h02;
      open_load_enable_i = 8'h13;
      analog_i.on_current_low = 8'h0f;
      analog_i.off_current_low = 8'hf0;
      cyc(5);
      chk("realtime open load", 8'h11, realtime_o.open_load);
      analog_i.on_current_low = '0;
      analog_i.off_current_low = '0;
      push_pull_i = '0;
      cyc(STR + 10);
      command_protocol_select_i = 1'b1;
      cyc(4);
      frame(16'h0080, 0, 1, 0, 0);
      chk("fault_n_o", 1, fault_n_o);
      analog_i.vdd_warn = 1'b1;
      cyc(5);
      analog_i.vdd_warn = 1'b0;
      cyc(20);
      chk("fault_n_o", 0, fault_n_o);
      frame(16'h0080, 0, 1, 1, 0);
      chk("latched warn bit", 1, latched_o.global_faults[G_VDD_WARN]);
      frame(16'h0080, 0, 1, 0, 0);
      frame(16'h0080, 0, 1, 0, 0);
      chk("latched_o", 0, latched_o);
      chk("fault_n_o", 1, fault_n_o);
      command_protocol_select_i = 1'b0;
      k = $urandom_range(7, 0);
      analog_i.over_current = 8'h01 << k;
      cyc(5);
      chk("overvoltage_slow_flag_o", 8'h01 << k, overvoltage_slow_flag_o);
      analog_i.over_current = '0;
      cyc(int'(ALERT_PULSE_CYCLES) - 40);
      chk("fault_n_o", 0, fault_n_o);
      cyc(60);
      chk("fault_n_o", 1, fault_n_o);
      watchdog_enable_i = 1'b1;
      frame(16'($urandom), 0, 1, 0, 0);
      cyc(100);
      chk("watchdog_alert_out_o", 0, watchdog_alert_out_o);
      cyc(60);
      chk("watchdog_alert_out_o", 1, watchdog_alert_out_o);
      chk("latched watchdog bit", 1, latched_o.global_faults[G_WATCHDOG]);
      frame(16'($urandom), 0, 1, 0, 0);
      chk("watchdog_alert_out_o", 0, watchdog_alert_out_o);
      watchdog_select_i = WD_SEL_MID;
      frame(16'($urandom), 0, 1, 0, 0);
      cyc(400);
      chk("watchdog_alert_out_o", 0, watchdog_alert_out_o);
      cyc(60);
      chk("watchdog_alert_out_o", 1, watchdog_alert_out_o);
      chk("pending frames", 0, exp_q.size());
      conclude();
   end
endmodule : tb
